//--- design/misc_ctrl.sv
// reset hand-off, self-test status, timeout, boot rom and clock select
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module misc_ctrl
	import misc_ctrl_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES,
	parameter int PULSE   = TOUT_PULSE,
	parameter int HALF    = BOOT_ROM_HALF
) (
	input  wire logic        pclk,                   // 200 MHz clock
	input  wire logic        presetn,                // async reset, low
	input  wire logic [7:0]  paddr,                  // apb address
	input  wire logic        psel,                   // apb select
	input  wire logic        penable,                // apb enable
	input  wire logic        pwrite,                 // apb direction
	input  wire logic [31:0] pwdata,                 // apb write data
	output logic      [31:0] prdata,                 // apb read data
	output logic             pready,                 // apb ready
	output logic             pslverr,                // apb error
	input  wire logic        sys_reset_n,            // board reset pin
	input  wire logic        supply_good_in,         // supply good pin
	input  wire logic        loop_bypass_sel,        // bypass pin
	input  wire logic        ref_clk_in_p,           // ref clock, true
	input  wire logic        ref_clk_in_n,           // ref clock, comp
	input  wire logic        boot_rom_serial_bit_in, // rom data pin
	input  wire logic        selftest_status_in,     // status pin level
	output od_pin_s          selftest_status_out,    // status pin drive
	output od_pin_s          boot_rom_serial_clk,    // rom clock drive
	output od_pin_s          boot_rom_out_en_n,      // rom enable drive
	input  wire logic        retire_pulse,           // instr retired
	input  wire logic        builtin_self_test_done,              // self test finished
	input  wire logic        builtin_self_test_pass,              // self test result
	output logic             builtin_self_test_start,             // self test begin
	output logic             core_reset_n,           // internal reset
	output logic             core_tick,              // core clock enable
	output logic             bypass_active           // raw clock in use
);
	localparam int TW = $clog2(TIMEOUT + 1);
	localparam int PW = $clog2(PULSE + 1);

	if (TIMEOUT < 1 || PULSE < 1 || HALF < 1) begin : g_bad_param
		$error("misc_ctrl: TIMEOUT, PULSE and HALF must be >= 1");
	end

	function automatic od_pin_s od_drive(input logic level);
		od_drive = '{out: 1'b0, oe_n: level};
	endfunction : od_drive

	//****************************************************************
	// pin synchronisers and reference clock edge
	//****************************************************************
	pin_in_s pins_raw;
	pin_in_s pins;

	assign pins_raw = '{
		sys_reset_n: sys_reset_n,
		supply_good: supply_good_in,
		bypass:      loop_bypass_sel,
		rom_bit:     boot_rom_serial_bit_in,
		ref_p:       ref_clk_in_p,
		ref_n:       ref_clk_in_n,
		status_pin:  selftest_status_in
	};

	pin_sync #(
		.WIDTH($bits(pin_in_s))
	) pin_sync_i (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (pins_raw),
		.q     (pins)
	);

	logic ref_prev_reg, ref_prev_next;
	logic tick_next, byp_next;
	logic ref_rise;

	always_comb begin
		ref_prev_next = pins.ref_p & ~pins.ref_n;
		ref_rise      = ref_prev_next & ~ref_prev_reg;
		byp_next      = pins.bypass;
		tick_next     = pins.bypass ? ref_rise : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_prev_reg  <= 1'b0;
			core_tick     <= 1'b0;
			bypass_active <= 1'b0;
		end else begin
			ref_prev_reg  <= ref_prev_next;
			core_tick     <= tick_next;
			bypass_active <= byp_next;
		end
	end

	//****************************************************************
	// apb registers
	//****************************************************************
	logic [1:0]  ctrl_reg, ctrl_next;
	logic        go_reg, go_next;
	logic        tmo_seen_reg, tmo_seen_next;
	logic [31:0] romd_reg, romd_next;
	logic [31:0] rdata_next;
	logic        ready_next, err_next;
	logic        setup, wr_acc, hit;
	logic        tmo_hit;
	logic        builtin_self_test_ok_reg;
	rst_state_e  state_reg;
	logic        rom_busy, rom_done;
	logic [31:0] rom_word;
	logic        rom_valid_reg, rom_valid_next;

	always_comb begin
		setup  = psel & ~penable;
		wr_acc = psel & penable & pwrite & pready;
		hit    = (paddr == CTRL_OFS) || (paddr == STAT_OFS)
			|| (paddr == ROMD_OFS);
		ready_next = setup;
		err_next   = setup & ~hit;
		rdata_next = prdata;
		if (setup) begin
			rdata_next = 32'h0000_0000;
			case (paddr)
				CTRL_OFS: begin
					rdata_next[1:0] = ctrl_reg;
				end
				STAT_OFS: begin
					rdata_next[STAT_STATE_LSB +: 2] = state_reg;
					rdata_next[STAT_PASS_BIT]  = builtin_self_test_ok_reg;
					rdata_next[STAT_TMO_BIT]   = tmo_seen_reg;
					rdata_next[STAT_BUSY_BIT]  = rom_busy;
					rdata_next[STAT_VALID_BIT] = rom_valid_reg;
					rdata_next[STAT_BYP_BIT]   = bypass_active;
					rdata_next[STAT_PIN_BIT]   = pins.status_pin;
				end
				ROMD_OFS: begin
					rdata_next = romd_reg;
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
		ctrl_next = ctrl_reg;
		go_next   = 1'b0;
		if (wr_acc && paddr == CTRL_OFS) begin
			ctrl_next = pwdata[1:0];
			go_next   = pwdata[CTRL_GO_BIT];
		end
		// a new timeout wins over a software clear
		tmo_seen_next = tmo_seen_reg;
		if (wr_acc && paddr == STAT_OFS && pwdata[STAT_TMO_BIT]) begin
			tmo_seen_next = 1'b0;
		end
		if (tmo_hit) begin
			tmo_seen_next = 1'b1;
		end
		romd_next      = rom_done ? rom_word : romd_reg;
		rom_valid_next = rom_valid_reg;
		if (go_reg) begin
			rom_valid_next = 1'b0;
		end
		if (rom_done) begin
			rom_valid_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= CTRL_RESET;
			go_reg        <= 1'b0;
			tmo_seen_reg  <= 1'b0;
			romd_reg      <= ROMD_RESET;
			rom_valid_reg <= 1'b0;
			prdata        <= 32'h0000_0000;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			go_reg        <= go_next;
			tmo_seen_reg  <= tmo_seen_next;
			romd_reg      <= romd_next;
			rom_valid_reg <= rom_valid_next;
			prdata        <= rdata_next;
			pready        <= ready_next;
			pslverr       <= err_next;
		end
	end

	//****************************************************************
	// reset sequence, self test and timeout
	//****************************************************************
	rst_state_e     state_next;
	logic [TW-1:0]  tcnt_reg, tcnt_next;
	logic [PW-1:0]  pcnt_reg, pcnt_next;
	logic           builtin_self_test_ok_next, start_next, crst_next;
	logic           stat_lvl;
	logic           sys_ok;

	always_comb begin
		sys_ok       = pins.sys_reset_n & pins.supply_good;
		state_next   = state_reg;
		tcnt_next    = tcnt_reg;
		pcnt_next    = pcnt_reg;
		builtin_self_test_ok_next = builtin_self_test_ok_reg;
		start_next   = 1'b0;
		tmo_hit      = 1'b0;
		case (state_reg)
			ST_HOLD: begin
				if (sys_ok) begin
					state_next   = ST_BUILTIN_SELF_TEST;
					start_next   = 1'b1;
					builtin_self_test_ok_next = 1'b0;
				end
			end
			ST_BUILTIN_SELF_TEST: begin
				if (builtin_self_test_done) begin
					builtin_self_test_ok_next = builtin_self_test_pass;
					state_next   = ST_RUN;
					tcnt_next    = '0;
				end
			end
			ST_RUN: begin
				if (retire_pulse || !ctrl_reg[CTRL_TMO_BIT]) begin
					tcnt_next = '0;
				end else if (core_tick) begin
					if (tcnt_reg == TW'(TIMEOUT - 1)) begin
						tmo_hit    = 1'b1;
						state_next = ST_TOUT;
						pcnt_next  = '0;
					end else begin
						tcnt_next = tcnt_reg + TW'(1);
					end
				end
			end
			ST_TOUT: begin
				if (core_tick) begin
					if (pcnt_reg == PW'(PULSE - 1)) begin
						state_next = ST_HOLD;
					end else begin
						pcnt_next = pcnt_reg + PW'(1);
					end
				end
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase
		if (!sys_ok) begin
			state_next = ST_HOLD;
			tcnt_next  = '0;
		end
		crst_next = (state_next == ST_BUILTIN_SELF_TEST) || (state_next == ST_RUN);
		case (state_next)
			ST_HOLD: stat_lvl = 1'b0;
			ST_BUILTIN_SELF_TEST: stat_lvl = 1'b1;
			ST_RUN:  stat_lvl = ~builtin_self_test_ok_next;
			ST_TOUT: stat_lvl = 1'b1;
			default: stat_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg           <= ST_HOLD;
			tcnt_reg            <= '0;
			pcnt_reg            <= '0;
			builtin_self_test_ok_reg         <= 1'b0;
			builtin_self_test_start          <= 1'b0;
			core_reset_n        <= 1'b0;
			selftest_status_out <= '{out: 1'b0, oe_n: 1'b0};
		end else begin
			state_reg           <= state_next;
			tcnt_reg            <= tcnt_next;
			pcnt_reg            <= pcnt_next;
			builtin_self_test_ok_reg         <= builtin_self_test_ok_next;
			builtin_self_test_start          <= start_next;
			core_reset_n        <= crst_next;
			selftest_status_out <= od_drive(stat_lvl);
		end
	end

	//****************************************************************
	// serial boot rom
	//****************************************************************
	logic rom_clk_lvl, rom_oe_n_lvl;

	rom_reader #(
		.HALF_TICKS (HALF),
		.WORD_BITS  (ROM_WORD_BITS)
	) rom_reader_i (
		.clk       (pclk),
		.rst_n     (presetn),
		.tick      (core_tick),
		.go        (go_reg),
		.bit_in    (pins.rom_bit),
		.clk_lvl   (rom_clk_lvl),
		.oe_n_lvl  (rom_oe_n_lvl),
		.busy      (rom_busy),
		.word      (rom_word),
		.word_done (rom_done)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_rom_serial_clk <= '{out: 1'b0, oe_n: 1'b0};
			boot_rom_out_en_n   <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			boot_rom_serial_clk <= od_drive(rom_clk_lvl);
			boot_rom_out_en_n   <= od_drive(rom_oe_n_lvl);
		end
	end
endmodule : misc_ctrl
`default_nettype wire

//--- design/misc_ctrl_pkg.sv
// package: constants, types and register map for the misc control block
//****************************************************************
// What this block does
// - release internal reset once reset pin and supply good
// - serial rom clock period is 256 core cycles
// - each rom clock advances rom; sample data line
// - drive rom output enable low while reading
// - status pin low while reset applied
// - status pin forced high when self test starts
// - self test pass lowers pin, fail keeps high
// - raise timeout reset after 1e9 cycles without retire
// - timeout pulses status pin for 256 core cycles
// - bypass selects raw reference clock as core tick
//****************************************************************
package misc_ctrl_pkg;

	//****************************************************************
	// register map
	//****************************************************************
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STAT_OFS       = 8'h04;
	localparam logic [7:0]  ROMD_OFS       = 8'h08;
	localparam int          CTRL_GO_BIT    = 0;
	localparam int          CTRL_TMO_BIT   = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h2;
	localparam int          STAT_STATE_LSB = 0;
	localparam int          STAT_PASS_BIT  = 2;
	localparam int          STAT_TMO_BIT   = 3;
	localparam int          STAT_BUSY_BIT  = 4;
	localparam int          STAT_VALID_BIT = 5;
	localparam int          STAT_BYP_BIT   = 6;
	localparam int          STAT_PIN_BIT   = 7;
	localparam logic [31:0] ROMD_RESET     = 32'h0000_0000;

	//****************************************************************
	// timing counts, in core ticks, and rom word width
	//****************************************************************
	localparam int BOOT_ROM_PERIOD = 256;
	localparam int BOOT_ROM_HALF   = BOOT_ROM_PERIOD / 2;
	localparam int ROM_WORD_BITS   = 32;
	localparam int TIMEOUT_CYCLES  = 1_000_000_000;
	localparam int TOUT_PULSE      = 256;

	//****************************************************************
	// types
	//****************************************************************
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_BUILTIN_SELF_TEST = 2'b01,
		ST_RUN  = 2'b11,
		ST_TOUT = 2'b10
	} rst_state_e;

	typedef struct packed {
		logic out;
		logic oe_n;
	} od_pin_s;

	typedef struct packed {
		logic sys_reset_n;
		logic supply_good;
		logic bypass;
		logic rom_bit;
		logic ref_p;
		logic ref_n;
		logic status_pin;
	} pin_in_s;

endpackage : misc_ctrl_pkg

//--- design/pin_sync.sv
// two-stage synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,    // sampling clock
	input  wire logic             rst_n,  // async reset, low
	input  wire logic [WIDTH-1:0] d,      // raw pins
	output logic      [WIDTH-1:0] q       // synchronised
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_next;

	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync: WIDTH must be at least 1");
	end

	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end
endmodule : pin_sync
`default_nettype wire

//--- design/rom_reader.sv
// serial boot rom bit reader with clock divider
`timescale 1ns/100ps
`default_nettype none
module rom_reader
	import misc_ctrl_pkg::*;
#(
	parameter int HALF_TICKS = BOOT_ROM_HALF,
	parameter int WORD_BITS  = ROM_WORD_BITS
) (
	input  wire logic                 clk,        // pclk
	input  wire logic                 rst_n,      // async reset, low
	input  wire logic                 tick,       // core tick enable
	input  wire logic                 go,         // start one word
	input  wire logic                 bit_in,     // synced rom data
	output logic                      clk_lvl,    // rom clock level
	output logic                      oe_n_lvl,   // rom enable, low
	output logic                      busy,       // word in progress
	output logic      [WORD_BITS-1:0] word,       // shifted word
	output logic                      word_done   // one-cycle pulse
);
	localparam int HW = $clog2(HALF_TICKS + 1);
	localparam int BW = $clog2(WORD_BITS + 1);

	logic [HW-1:0]        half_reg, half_next;
	logic [BW-1:0]        bits_reg, bits_next;
	logic                 clk_next, busy_next, done_next;
	logic [WORD_BITS-1:0] word_next;

	if (HALF_TICKS < 1 || WORD_BITS < 1) begin : g_bad_param
		$error("rom_reader: HALF_TICKS and WORD_BITS must be >= 1");
	end

	always_comb begin
		half_next = half_reg;
		bits_next = bits_reg;
		clk_next  = clk_lvl;
		busy_next = busy;
		word_next = word;
		done_next = 1'b0;
		if (!busy) begin
			if (go) begin
				busy_next = 1'b1;
				clk_next  = 1'b0;
				half_next = '0;
				bits_next = '0;
			end
		end else if (tick) begin
			if (half_reg == HW'(HALF_TICKS - 1)) begin
				half_next = '0;
				if (!clk_lvl) begin
					// sample just before the rising edge
					word_next = {word[WORD_BITS-2:0], bit_in};
					bits_next = bits_reg + BW'(1);
					if (bits_reg == BW'(WORD_BITS - 1)) begin
						busy_next = 1'b0;
						done_next = 1'b1;
					end else begin
						clk_next = 1'b1;
					end
				end else begin
					clk_next = 1'b0;
				end
			end else begin
				half_next = half_reg + HW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_reg  <= '0;
			bits_reg  <= '0;
			clk_lvl   <= 1'b0;
			oe_n_lvl  <= 1'b1;
			busy      <= 1'b0;
			word      <= '0;
			word_done <= 1'b0;
		end else begin
			half_reg  <= half_next;
			bits_reg  <= bits_next;
			clk_lvl   <= clk_next;
			oe_n_lvl  <= ~busy_next;
			busy      <= busy_next;
			word      <= word_next;
			word_done <= done_next;
		end
	end
endmodule : rom_reader
`default_nettype wire

//--- sim/misc_ctrl_props.sv
// checker: pin timing of the misc control block
`timescale 1ns/100ps
`default_nettype none
module misc_ctrl_props
	import misc_ctrl_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES,
	parameter int PULSE   = TOUT_PULSE,
	parameter int HALF    = BOOT_ROM_HALF
) (
	input wire logic    pclk,                // clock
	input wire logic    presetn,             // reset, low
	input wire logic    sys_reset_n,         // board reset
	input wire logic    supply_good_in,      // supply good
	input wire logic    retire_pulse,        // retired
	input wire logic    builtin_self_test_done,           // test end
	input wire logic    builtin_self_test_pass,           // test result
	input wire logic    builtin_self_test_start,          // test begin
	input wire logic    core_reset_n,        // internal reset
	input wire logic    core_tick,           // core tick
	input wire logic    bypass_active,       // bypass in use
	input wire od_pin_s selftest_status_out, // status drive
	input wire od_pin_s boot_rom_serial_clk, // rom clock
	input wire od_pin_s boot_rom_out_en_n    // rom enable
);
	logic st, rc, re, in_builtin_self_test_reg, in_builtin_self_test_next, rc_reg;
	int   tout_reg, tout_next, idle_reg, idle_next, run_reg, run_next;
	assign st = selftest_status_out.oe_n;
	assign rc = boot_rom_serial_clk.oe_n;
	assign re = boot_rom_out_en_n.oe_n;
	// tracks test phase, pulse length, stall and rom level run
	always_comb begin
		in_builtin_self_test_next = builtin_self_test_start | (in_builtin_self_test_reg & ~builtin_self_test_done & core_reset_n);
		tout_next = (!core_reset_n && st) ? tout_reg + 1 : 0;
		idle_next = (retire_pulse || !core_reset_n) ? 0 : idle_reg + 1;
		run_next = (rc != rc_reg) ? 1 : run_reg + 1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_builtin_self_test_reg <= 1'b0;
			rc_reg <= 1'b0;
			tout_reg <= 0;
			idle_reg <= 0;
			run_reg <= 0;
		end else begin
			in_builtin_self_test_reg <= in_builtin_self_test_next;
			rc_reg <= rc;
			tout_reg <= tout_next;
			idle_reg <= idle_next;
			run_reg <= run_next;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence tout_begin_s;
		$fell(core_reset_n) && st;
	endsequence
	sequence tout_end_s;
		$fell(st) && !$past(core_reset_n) && !core_reset_n;
	endsequence
	chk_status_rst_low: assert property (!sys_reset_n [*5] |-> !st)
		else $error("status pin not low in reset");
	chk_release_cause: assert property ($rose(core_reset_n) |->
		$past(sys_reset_n, 3) && $past(supply_good_in, 3))
		else $error("reset released without board ready");
	chk_builtin_self_test_raise: assert property ($rose(core_reset_n) |-> builtin_self_test_start && st)
		else $error("status not high at test start");
	chk_builtin_self_test_result: assert property (in_builtin_self_test_reg && builtin_self_test_done |=>
		st == !$past(builtin_self_test_pass))
		else $error("status wrong after test");
	chk_tout_idle: assert property (tout_begin_s |-> idle_reg >= TIMEOUT - 1)
		else $error("timeout too early");
	chk_tout_pulse: assert property (@(posedge pclk)
		disable iff (!presetn || bypass_active) tout_end_s |-> tout_reg == PULSE)
		else $error("timeout pulse length wrong");
	chk_rom_half: assert property ($fell(rc) && !bypass_active |->
		run_reg == HALF)
		else $error("rom clock high half wrong");
	chk_rom_enabled: assert property ($rose(rc) |-> !re)
		else $error("rom clock edge with rom disabled");
	chk_tick_pulse: assert property (bypass_active && core_tick ##1
		bypass_active |-> !core_tick)
		else $error("bypass tick longer than one cycle");
	chk_tick_steady: assert property (!bypass_active [*3] |-> core_tick)
		else $error("core tick missing without bypass");
endmodule : misc_ctrl_props
bind misc_ctrl misc_ctrl_props #(.TIMEOUT(TIMEOUT), .PULSE(PULSE), .HALF(HALF))
	misc_ctrl_props_i (.pclk(pclk), .presetn(presetn),
	.sys_reset_n(sys_reset_n), .supply_good_in(supply_good_in),
	.retire_pulse(retire_pulse), .builtin_self_test_done(builtin_self_test_done), .builtin_self_test_pass(builtin_self_test_pass),
	.builtin_self_test_start(builtin_self_test_start), .core_reset_n(core_reset_n),
	.core_tick(core_tick), .bypass_active(bypass_active),
	.selftest_status_out(selftest_status_out),
	.boot_rom_serial_clk(boot_rom_serial_clk),
	.boot_rom_out_en_n(boot_rom_out_en_n));
`default_nettype wire

//--- sim/board_model.sv
// board model: serial boot rom and status pin pull-up
`timescale 1ns/100ps
`default_nettype none
module board_model (
	input  wire logic        pclk,        // sampling clock
	input  wire logic        rom_clk,     // rom clock wire
	input  wire logic        rom_en_n,    // rom enable wire
	input  wire logic        status_oe_n, // status drive enable
	input  wire logic [31:0] word,        // rom contents
	output logic             rom_bit,     // rom data wire
	output logic             status_lvl   // status wire
);
	logic [4:0] idx   = 5'h1F;
	logic       clk_d = 1'b0;
	logic       last  = 1'b0;
	// pull-up holds the pin high when released
	assign status_lvl = status_oe_n;
	// released data line shows inverse of last bit
	assign rom_bit = rom_en_n ? ~last : word[idx];
	always @(posedge pclk) begin
		clk_d <= rom_clk;
		if (rom_en_n) begin
			idx <= 5'h1F;
		end else if (rom_clk && !clk_d) begin
			idx <= idx - 5'h01;
		end
		if (!rom_en_n) begin
			last <= rom_bit;
		end
	end
endmodule : board_model
`default_nettype wire

//--- sim/misc_ctrl_test.sv
// testbench: misc control block against board model
`timescale 1ns/100ps
`default_nettype none
module misc_ctrl_test
	import misc_ctrl_pkg::*;
;
	localparam int TMO = 50;
	localparam int PLS = 8;
	localparam int HLF = 4;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, err, p, rom_bit, status_lvl;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, rom_word = 32'h0;
	logic        sys_reset_n = 1'b0, supply_good_in = 1'b0;
	logic        loop_bypass_sel = 1'b0, ref_clk_in_p = 1'b0, ref_clk_in_n = 1'b1;
	logic        retire_pulse = 1'b0, retiring = 1'b1;
	logic        builtin_self_test_done = 1'b0, builtin_self_test_pass = 1'b0;
	logic        builtin_self_test_start, core_reset_n, core_tick, bypass_active;
	od_pin_s     st_o, rc_o, re_o;
	int          rgap = 0, n, miscompares = 0, checks_done = 0;

	misc_ctrl #(.TIMEOUT(TMO), .PULSE(PLS), .HALF(HLF)) misc_ctrl_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sys_reset_n(sys_reset_n),
		.supply_good_in(supply_good_in), .loop_bypass_sel(loop_bypass_sel),
		.ref_clk_in_p(ref_clk_in_p), .ref_clk_in_n(ref_clk_in_n),
		.boot_rom_serial_bit_in(rom_bit), .selftest_status_in(status_lvl),
		.selftest_status_out(st_o), .boot_rom_serial_clk(rc_o),
		.boot_rom_out_en_n(re_o), .retire_pulse(retire_pulse),
		.builtin_self_test_done(builtin_self_test_done), .builtin_self_test_pass(builtin_self_test_pass), .builtin_self_test_start(builtin_self_test_start),
		.core_reset_n(core_reset_n), .core_tick(core_tick),
		.bypass_active(bypass_active));
	board_model board_model_i (.pclk(pclk), .rom_clk(rc_o.oe_n),
		.rom_en_n(re_o.oe_n), .status_oe_n(st_o.oe_n), .word(rom_word),
		.rom_bit(rom_bit), .status_lvl(status_lvl));

	//****************************************
	// clocks, retire traffic, watchdog
	//****************************************
	always #2.5 pclk = ~pclk;
	initial begin
		#13.3;
		forever begin
			ref_clk_in_p = ~ref_clk_in_p;
			ref_clk_in_n = ~ref_clk_in_p;
			#40;
		end
	end
	// retire gaps stay shorter than the timeout
	always @(posedge pclk) begin
		rgap <= (rgap == 0) ? $urandom_range(TMO - 10, 1) : rgap - 1;
		retire_pulse <= retiring && rgap == 0;
	end
	// whole run needs about 1500 cycles
	initial begin
		repeat (30000) @(posedge pclk);
		miscompares++;
		test_done;
	end

	//****************************************
	// tasks
	//****************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task chk_bit(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task builtin_self_test(input logic pass);
		n = 0;
		while (builtin_self_test_start !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk_bit("builtin_self_test_start", 1'b1, builtin_self_test_start);
		chk_bit("status_start", 1'b1, status_lvl);
		builtin_self_test_pass <= pass;
		builtin_self_test_done <= 1'b1;
		@(posedge pclk);
		builtin_self_test_done <= 1'b0;
		cyc(2);
		chk_bit("status_end", ~pass, status_lvl);
	endtask : builtin_self_test
	task brd(input logic pass);
		sys_reset_n <= 1'b0;
		cyc(6);
		chk_bit("status_rst", 1'b0, status_lvl);
		chk_bit("core_rst", 1'b0, core_reset_n);
		sys_reset_n <= 1'b1;
		builtin_self_test(pass);
	endtask : brd
	task test_done;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	//****************************************
	// main sequence
	//****************************************
	initial begin
		void'($urandom(32'h09C6));
		cyc(5);
		presetn <= 1'b1;
		cyc(8);
		chk_bit("status_pwr", 1'b0, status_lvl);
		supply_good_in <= 1'b1;
		brd(1'b1);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl_rst", {30'h0, CTRL_RESET}, rd);
		apb(1'b0, ROMD_OFS, 32'h0);
		chk("romd_rst", ROMD_RESET, rd);
		apb(1'b0, 8'h0C, 32'h0);
		chk_bit("unmapped", 1'b1, err);
		chk("unmapped_rd", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			p = (i == 0) ? 1'b0 : (i == 3) ? 1'b1 : 1'($urandom_range(1, 0));
			brd(p);
		end
		apb(1'b0, STAT_OFS, 32'h0);
		chk("state_run", {30'h0, ST_RUN}, {30'h0, rd[1:0]});
		for (int i = 0; i < 3; i++) begin
			rom_word <= (i == 0) ? 32'h8000_0001 : $urandom;
			apb(1'b1, CTRL_OFS, 32'h3);
			cyc(4);
			n = 0;
			do begin
				apb(1'b0, STAT_OFS, 32'h0);
				n++;
			end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 200);
			apb(1'b0, ROMD_OFS, 32'h0);
			chk("rom_word", rom_word, rd);
			chk_bit("rom_en_off", 1'b1, re_o.oe_n);
			chk("od_out", 32'h0, {29'h0, st_o.out, rc_o.out, re_o.out});
		end
		apb(1'b0, STAT_OFS, 32'h0);
		chk_bit("tout_none", 1'b0, rd[STAT_TMO_BIT]);
		chk_bit("rom_valid", 1'b1, rd[STAT_VALID_BIT]);
		chk_bit("test_pass", 1'b1, rd[STAT_PASS_BIT]);
		chk_bit("pin_rd", 1'b0, rd[STAT_PIN_BIT]);
		while (retire_pulse !== 1'b1) @(posedge pclk);
		retiring <= 1'b0;
		n = 0;
		while (core_reset_n === 1'b1 && n < TMO + 20) begin
			@(posedge pclk);
			n++;
		end
		chk_bit("tout_time", 1'b1, n >= TMO - 1 && n <= TMO + 4);
		n = 0;
		while (status_lvl === 1'b1 && core_reset_n === 1'b0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk("tout_pulse", PLS, n);
		retiring <= 1'b1;
		builtin_self_test(1'b1);
		apb(1'b0, STAT_OFS, 32'h0);
		chk_bit("tout_seen", 1'b1, rd[STAT_TMO_BIT]);
		apb(1'b1, STAT_OFS, 32'h1 << STAT_TMO_BIT);
		apb(1'b0, STAT_OFS, 32'h0);
		chk_bit("tout_clr", 1'b0, rd[STAT_TMO_BIT]);
		apb(1'b1, CTRL_OFS, 32'h0);
		retiring <= 1'b0;
		cyc(TMO + 20);
		chk_bit("tout_off", 1'b1, core_reset_n);
		retiring <= 1'b1;
		apb(1'b1, CTRL_OFS, {30'h0, CTRL_RESET});
		loop_bypass_sel <= 1'b1;
		cyc(10);
		chk_bit("byp_on", 1'b1, bypass_active);
		n = 0;
		repeat (320) begin
			@(posedge pclk);
			n += int'(core_tick === 1'b1);
		end
		chk_bit("byp_rate", 1'b1, n >= 19 && n <= 21);
		loop_bypass_sel <= 1'b0;
		cyc(6);
		chk_bit("tick_on", 1'b1, core_tick);
		test_done;
	end
endmodule : misc_ctrl_test
`default_nettype wire
